/* File: verilog/can_mb_pkg.sv */
// Constants and types for the CAN message buffer control block
package can_mb_pkg;

  localparam int NUM_BUF  = 32;
  localparam int NUM_TX   = 8;
  localparam int ADDR_W   = 9;
  localparam int WORDS    = 8;

  localparam logic [8:0] OFF_CTRL0   = 9'h000;
  localparam logic [8:0] OFF_FULL_LO = 9'h004;
  localparam logic [8:0] OFF_FULL_HI = 9'h005;
  localparam logic [8:0] OFF_OVF_HI  = 9'h006;
  localparam logic [8:0] OFF_RAM     = 9'h100;

  localparam logic [2:0] W_SID  = 3'h0;
  localparam logic [2:0] W_EID  = 3'h1;
  localparam logic [2:0] W_DLC  = 3'h2;
  localparam logic [2:0] W_STAT = 3'h7;

  localparam logic [15:0] MASK_SID  = 16'h1FFF;
  localparam logic [15:0] MASK_EID  = 16'h0FFF;
  localparam logic [15:0] MASK_DLC  = 16'hFF1F;
  localparam logic [15:0] MASK_STAT = 16'h1F00;
  localparam logic [15:0] MASK_DATA = 16'hFFFF;

  localparam int          IDE_BIT   = 0;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;

  typedef struct packed {
    logic       buffer_direction_select;
    logic       tx_aborted_flag;
    logic       tx_lost_arbitration_flag;
    logic       tx_bus_error_flag;
    logic       send_request;
    logic       auto_remote_reply_enable;
    logic [1:0] tx_priority;
  } ctrl_byte_t;

  localparam ctrl_byte_t RST_CTRL = 8'h00;

  typedef enum logic [1:0] {
    TX_OK      = 2'b00,
    TX_LOST    = 2'b01,
    TX_ERR     = 2'b10,
    TX_ABORTED = 2'b11
  } tx_kind_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] buf_idx;
    tx_kind_t   kind;
  } tx_result_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  buf_idx;
    logic [2:0]  word_sel;
    logic        last;
    logic [15:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] buf_idx;
  } remote_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] buf_idx;
    logic [1:0] prio;
    logic       ext_id;
  } tx_offer_t;

endpackage : can_mb_pkg

/* File: verilog/can_message_buffer_control.sv */
// CAN message buffer control, flags and message RAM
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
module can_message_buffer_control #(
  parameter int NUM_TX_BUF = 8
) (
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire logic [8:0]            reg_addr_in,
  input  wire logic [15:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [15:0]                reg_rdata_out,
  input  wire can_mb_pkg::rx_beat_t  rx_beat_in,
  output logic                       rx_beat_ready_out,
  input  wire can_mb_pkg::remote_t   remote_in,
  input  wire can_mb_pkg::tx_result_t tx_result_in,
  output can_mb_pkg::tx_offer_t      tx_offer_out,
  output logic [7:0]                 abort_req_out
);

  if (NUM_TX_BUF != can_mb_pkg::NUM_TX) begin : g_bad_tx
    $error("NUM_TX_BUF must equal the control register capacity");
  end

  can_mb_pkg::ctrl_byte_t ctrl_reg   [8];
  can_mb_pkg::ctrl_byte_t ctrl_next  [8];
  logic [7:0]             abort_reg;
  logic [7:0]             abort_next;
  logic [31:0]            full_reg;
  logic [31:0]            full_next;
  logic [15:0]            ovf_reg;
  logic [15:0]            ovf_next;
  logic [7:0]             ide_reg;
  logic [15:0]            msg_ram    [256];
  logic                   sw_ram_wr;
  logic                   beat_take;
  logic                   beat_blocked;
  logic                   beat_write;
  logic                   beat_is_tx;
  logic                   beat_full;
  logic [7:0]             beat_addr;
  logic [15:0]            sw_wmask;
  logic [15:0]            hw_wmask;
  logic                   best_valid;
  logic [2:0]             best_idx;
  logic [1:0]             best_prio;

  function automatic logic [15:0] word_mask(input logic [2:0] sel);
    logic [15:0] m;
    m = can_mb_pkg::MASK_DATA;
    unique case (sel)
      can_mb_pkg::W_SID:  m = can_mb_pkg::MASK_SID;
      can_mb_pkg::W_EID:  m = can_mb_pkg::MASK_EID;
      can_mb_pkg::W_DLC:  m = can_mb_pkg::MASK_DLC;
      can_mb_pkg::W_STAT: m = can_mb_pkg::MASK_STAT;
      default:            m = can_mb_pkg::MASK_DATA;
    endcase
    return m;
  endfunction : word_mask

  // Message words sit behind bit 8 of the address, apart from control
  assign sw_ram_wr = reg_wr_in && reg_addr_in[8];
  assign sw_wmask  = word_mask(reg_addr_in[2:0]);

  // Engine stalls while software writes the RAM; one write port only
  assign rx_beat_ready_out = !sw_ram_wr;
  assign beat_take  = rx_beat_in.valid && rx_beat_ready_out;
  assign beat_addr  = {rx_beat_in.buf_idx, rx_beat_in.word_sel};
  assign hw_wmask   = word_mask(rx_beat_in.word_sel);
  assign beat_full  = full_reg[rx_beat_in.buf_idx];
  assign beat_is_tx = (rx_beat_in.buf_idx < 5'(can_mb_pkg::NUM_TX)) &&
                      ctrl_reg[rx_beat_in.buf_idx[2:0]].buffer_direction_select;
  // Transmit buffers are never written with received content
  assign beat_blocked = beat_full || beat_is_tx;
  assign beat_write   = beat_take && !beat_blocked;

  always_ff @(posedge clk_in) begin
    if (sw_ram_wr) begin
      msg_ram[reg_addr_in[7:0]] <= reg_wdata_in & sw_wmask;
    end else if (beat_write) begin
      msg_ram[beat_addr] <= rx_beat_in.data & hw_wmask;
    end
  end

  // Shadow of the IDE bit for the transmit-capable buffers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ide_reg <= 8'h00;
    end else if (sw_ram_wr && reg_addr_in[2:0] == can_mb_pkg::W_SID && reg_addr_in[7:6] == 2'h0) begin
      ide_reg[reg_addr_in[5:3]] <= reg_wdata_in[can_mb_pkg::IDE_BIT];
    end else if (beat_write && rx_beat_in.word_sel == can_mb_pkg::W_SID && rx_beat_in.buf_idx[4:3] == 2'h0) begin
      ide_reg[rx_beat_in.buf_idx[2:0]] <= rx_beat_in.data[can_mb_pkg::IDE_BIT];
    end
  end

  // Full and overflow flags; hardware set wins over software clear
  always_comb begin
    full_next = full_reg;
    ovf_next  = ovf_reg;
    if (reg_wr_in && reg_addr_in == can_mb_pkg::OFF_FULL_LO) begin
      full_next[15:0] = full_reg[15:0] & reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == can_mb_pkg::OFF_FULL_HI) begin
      full_next[31:16] = full_reg[31:16] & reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == can_mb_pkg::OFF_OVF_HI) begin
      ovf_next = ovf_reg & reg_wdata_in;
    end
    if (beat_take && rx_beat_in.last && !beat_is_tx) begin
      if (beat_full) begin
        if (rx_beat_in.buf_idx[4]) begin
          ovf_next[rx_beat_in.buf_idx[3:0]] = 1'b1;
        end
      end else begin
        full_next[rx_beat_in.buf_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      full_reg <= can_mb_pkg::RST_FLAGS;
      ovf_reg  <= can_mb_pkg::RST_FLAGS[15:0];
    end else begin
      full_reg <= full_next;
      ovf_reg  <= ovf_next;
    end
  end

  // Control bytes for buffers 0 to 7
  always_comb begin
    can_mb_pkg::ctrl_byte_t c;
    can_mb_pkg::ctrl_byte_t wb;
    logic                   hit;
    logic                   res;
    c   = can_mb_pkg::RST_CTRL;
    wb  = can_mb_pkg::RST_CTRL;
    hit = 1'b0;
    res = 1'b0;
    abort_next = abort_reg;
    for (int i = 0; i < can_mb_pkg::NUM_TX; i++) begin
      c   = ctrl_reg[i];
      hit = reg_wr_in && (reg_addr_in == can_mb_pkg::OFF_CTRL0 + 9'(i >> 1));
      wb  = (i % 2 == 1) ? reg_wdata_in[15:8] : reg_wdata_in[7:0];
      res = tx_result_in.valid && (tx_result_in.buf_idx == 3'(i));
      // Completion clears the request first so a new software set wins
      if (res && tx_result_in.kind == can_mb_pkg::TX_OK) begin
        c.send_request    = 1'b0;
        c.tx_aborted_flag = 1'b0;
        abort_next[i]     = 1'b0;
      end
      if (res && tx_result_in.kind == can_mb_pkg::TX_ABORTED) begin
        c.send_request = 1'b0;
        abort_next[i]  = 1'b0;
      end
      if (hit) begin
        c.buffer_direction_select  = wb.buffer_direction_select;
        c.auto_remote_reply_enable = wb.auto_remote_reply_enable;
        c.tx_priority              = wb.tx_priority;
        if (wb.send_request) begin
          c.send_request             = 1'b1;
          c.tx_aborted_flag          = 1'b0;
          c.tx_lost_arbitration_flag = 1'b0;
          c.tx_bus_error_flag        = 1'b0;
          abort_next[i]              = 1'b0;
        end else if (ctrl_reg[i].send_request) begin
          // Request stays set until the engine reports the abort
          abort_next[i] = 1'b1;
        end
      end
      if (remote_in.valid && remote_in.buf_idx == 5'(i) &&
          c.buffer_direction_select && c.auto_remote_reply_enable) begin
        c.send_request             = 1'b1;
        c.tx_aborted_flag          = 1'b0;
        c.tx_lost_arbitration_flag = 1'b0;
        c.tx_bus_error_flag        = 1'b0;
      end
      // Outcome flags last: a hardware set beats a same-cycle clear
      if (res) begin
        unique case (tx_result_in.kind)
          can_mb_pkg::TX_OK:      c.tx_aborted_flag = c.tx_aborted_flag;
          can_mb_pkg::TX_LOST:    c.tx_lost_arbitration_flag = 1'b1;
          can_mb_pkg::TX_ERR:     c.tx_bus_error_flag = 1'b1;
          can_mb_pkg::TX_ABORTED: c.tx_aborted_flag = 1'b1;
        endcase
      end
      ctrl_next[i] = c;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      abort_reg <= 8'h00;
      for (int i = 0; i < can_mb_pkg::NUM_TX; i++) begin
        ctrl_reg[i] <= can_mb_pkg::RST_CTRL;
      end
    end else begin
      abort_reg <= abort_next;
      for (int i = 0; i < can_mb_pkg::NUM_TX; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
    end
  end

  // Priority pick; ties go to the lower buffer number
  always_comb begin
    best_valid = 1'b0;
    best_idx   = 3'h0;
    best_prio  = 2'h0;
    for (int i = 0; i < can_mb_pkg::NUM_TX; i++) begin
      if (ctrl_reg[i].send_request && ctrl_reg[i].buffer_direction_select && !abort_reg[i] &&
          (!best_valid || ctrl_reg[i].tx_priority > best_prio)) begin
        best_valid = 1'b1;
        best_idx   = 3'(i);
        best_prio  = ctrl_reg[i].tx_priority;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_offer_out  <= '0;
      abort_req_out <= 8'h00;
    end else begin
      tx_offer_out.valid   <= best_valid;
      tx_offer_out.buf_idx <= best_idx;
      tx_offer_out.prio    <= best_prio;
      tx_offer_out.ext_id  <= ide_reg[best_idx];
      abort_req_out        <= abort_next;
    end
  end

  // Read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= can_mb_pkg::RST_WORD;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= can_mb_pkg::RST_WORD;
    end else if (reg_addr_in[8]) begin
      reg_rdata_out <= msg_ram[reg_addr_in[7:0]];
    end else if (reg_addr_in[8:2] == can_mb_pkg::OFF_CTRL0[8:2]) begin
      reg_rdata_out <= {ctrl_reg[{reg_addr_in[1:0], 1'b1}], ctrl_reg[{reg_addr_in[1:0], 1'b0}]};
    end else if (reg_addr_in == can_mb_pkg::OFF_FULL_LO) begin
      reg_rdata_out <= full_reg[15:0];
    end else if (reg_addr_in == can_mb_pkg::OFF_FULL_HI) begin
      reg_rdata_out <= full_reg[31:16];
    end else if (reg_addr_in == can_mb_pkg::OFF_OVF_HI) begin
      reg_rdata_out <= ovf_reg;
    end else begin
      reg_rdata_out <= can_mb_pkg::RST_WORD;
    end
  end

endmodule : can_message_buffer_control

/* File: dv/can_mb_checker_assertions.sv */
// Port checker for the CAN message buffer control block
`timescale 1ns/10ps
module can_mb_checker (
  input wire logic                   clk_in,
  input wire logic                   srst_in,
  input wire logic [8:0]             reg_addr_in,
  input wire logic [15:0]            reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [15:0]            reg_rdata_out,
  input wire logic                   rx_beat_ready_out,
  input wire can_mb_pkg::tx_result_t tx_result_in,
  input wire logic [7:0]             abort_req_out
);
  logic [2:0] ev_idx;
  logic [2:0] ab_idx;
  assign ev_idx = {reg_addr_in[1:0], 1'h0};
  assign ab_idx = tx_result_in.buf_idx;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_ram_rd(logic [2:0] w);
    reg_rd_in && reg_addr_in[8] && reg_addr_in[2:0] == w;
  endsequence
  sequence s_wr_ctrl;
    reg_wr_in && reg_addr_in < 9'h004;
  endsequence
  sequence s_rd_back;
    reg_rd_in && reg_addr_in == $past(reg_addr_in, 2);
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000) else $error("read data not zero");
  a_unmapped_read: assert property (reg_rd_in && reg_addr_in inside {[9'h007:9'h0FF]} |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_sid_upper_zero: assert property (s_ram_rd(3'h0) |=> reg_rdata_out[15:13] == 3'h0) else $error("sid upper bits");
  a_eid_upper_zero: assert property (s_ram_rd(3'h1) |=> reg_rdata_out[15:12] == 4'h0) else $error("eid upper bits");
  a_dlc_gap_zero: assert property (s_ram_rd(3'h2) |=> reg_rdata_out[7:5] == 3'h0) else $error("length gap bits");
  a_stat_only_filter: assert property (s_ram_rd(3'h7) |=> (reg_rdata_out & 16'hE0FF) == 16'h0000)
    else $error("status word stray bits");
  a_ready_blocked: assert property (reg_wr_in && reg_addr_in[8] |-> !rx_beat_ready_out) else $error("ready during ram write");
  a_ctrl_readback: assert property (s_wr_ctrl ##2 s_rd_back |=>
    (reg_rdata_out & 16'h8787) == ($past(reg_wdata_in, 3) & 16'h8787)) else $error("control readback");
  a_req_clr_abort: assert property (s_wr_ctrl and reg_wdata_in[3] |=> !abort_req_out[$past(ev_idx)])
    else $error("abort kept after request");
  a_abort_done: assert property (tx_result_in.valid && tx_result_in.kind == can_mb_pkg::TX_ABORTED
    |=> !abort_req_out[$past(ab_idx)]) else $error("abort kept after aborted");
endmodule : can_mb_checker
bind can_message_buffer_control can_mb_checker chk (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .rx_beat_ready_out(rx_beat_ready_out), .tx_result_in(tx_result_in), .abort_req_out(abort_req_out));

/* File: dv/can_bus_model.sv */
// Bus-side engine model: receive words, remote frames, send outcomes
`timescale 1ns/10ps
module can_bus_model (
  input  wire logic              clk_in,
  input  wire logic              rx_beat_ready_in,
  output can_mb_pkg::rx_beat_t   rx_beat_out,
  output can_mb_pkg::remote_t    remote_out,
  output can_mb_pkg::tx_result_t tx_result_out
);
  initial begin
    rx_beat_out = '0;
    remote_out = '0;
    tx_result_out = '0;
  end
  // Word held until taken; released fields inverted so stale data never matches
  task automatic beat(input logic [4:0] b, input logic [2:0] w, input logic l, input logic [15:0] d);
    @(posedge clk_in);
    rx_beat_out <= '{1'h1, b, w, l, d};
    do @(posedge clk_in); while (!rx_beat_ready_in);
    rx_beat_out <= '{1'h0, ~b, ~w, ~l, ~d};
  endtask : beat
  task automatic remote(input logic [4:0] b);
    @(posedge clk_in);
    remote_out <= '{1'h1, b};
    @(posedge clk_in);
    remote_out <= '{1'h0, ~b};
  endtask : remote
  task automatic result(input logic [2:0] b, input can_mb_pkg::tx_kind_t k);
    @(posedge clk_in);
    tx_result_out <= '{1'h1, b, k};
    @(posedge clk_in);
    tx_result_out <= '{1'h0, ~b, k};
  endtask : result
endmodule : can_bus_model

/* File: dv/tb.sv */
// Testbench for the CAN message buffer control block
`timescale 1ns/10ps
module tb;
  logic                   clk_in = 1'h0;
  logic                   srst_in = 1'h1;
  logic [8:0]             addr = 9'h000;
  logic [15:0]            wdata = 16'h0000;
  logic                   wr_s = 1'h0;
  logic                   rd_s = 1'h0;
  logic [15:0]            rdata;
  logic                   ready;
  logic [7:0]             abort_req;
  can_mb_pkg::rx_beat_t   beat_s;
  can_mb_pkg::remote_t    remote_s;
  can_mb_pkg::tx_result_t result_s;
  can_mb_pkg::tx_offer_t  offer;
  int                     fail_count = 0;
  int                     n_compared = 0;
  always #50 clk_in = ~clk_in;
  can_bus_model eng (.clk_in(clk_in), .rx_beat_ready_in(ready), .rx_beat_out(beat_s), .remote_out(remote_s),
    .tx_result_out(result_s));
  can_message_buffer_control dut (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .rx_beat_in(beat_s), .rx_beat_ready_out(ready),
    .remote_in(remote_s), .tx_result_in(result_s), .tx_offer_out(offer), .abort_req_out(abort_req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk_in);
    wr_s <= 1'h0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk_in);
    rd_s <= 1'h0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'h0;
    for (int i = 0; i < 8; i++) rd(9'(i), 16'h0000);
    wr(9'h108, 16'hFFFF);
    rd(9'h108, 16'h1FFF);
    wr(9'h109, 16'hFFFF);
    rd(9'h109, 16'h0FFF);
    wr(9'h10A, 16'hFEEF);
    rd(9'h10A, 16'hFE0F);
    wr(9'h10B, 16'h5AA5);
    rd(9'h10B, 16'h5AA5);
    wr(9'h100, 16'h0004);
    wr(9'h000, 16'h8B8A);
    rd(9'h000, 16'h8B8A);
    repeat (3) @(posedge clk_in);
    #1 chk({9'h000, offer}, {9'h000, 1'h1, 3'h1, 2'h3, 1'h1});
    eng.result(3'h1, can_mb_pkg::TX_LOST);
    rd(9'h000, 16'hAB8A);
    eng.result(3'h1, can_mb_pkg::TX_ERR);
    rd(9'h000, 16'hBB8A);
    wr(9'h000, 16'h8B8A);
    rd(9'h000, 16'h8B8A);
    wr(9'h000, 16'h838A);
    #1 chk({8'h00, abort_req}, 16'h0002);
    rd(9'h000, 16'h8B8A);
    eng.result(3'h1, can_mb_pkg::TX_ABORTED);
    rd(9'h000, 16'hC38A);
    repeat (3) @(posedge clk_in);
    #1 chk({9'h000, offer}, {9'h000, 1'h1, 3'h0, 2'h2, 1'h0});
    eng.result(3'h0, can_mb_pkg::TX_OK);
    rd(9'h000, 16'hC382);
    wr(9'h001, 16'h8084);
    eng.remote(5'h02);
    eng.remote(5'h03);
    rd(9'h001, 16'h808C);
    eng.beat(5'h14, 3'h7, 1'h1, 16'hFFFF);
    rd(9'h1A7, 16'h1F00);
    rd(9'h005, 16'h0010);
    eng.beat(5'h14, 3'h7, 1'h1, 16'h0000);
    rd(9'h1A7, 16'h1F00);
    rd(9'h006, 16'h0010);
    wr(9'h006, 16'hFFEF);
    wr(9'h005, 16'hFFEF);
    rd(9'h006, 16'h0000);
    rd(9'h005, 16'h0000);
    wr(9'h107, 16'h0000);
    eng.beat(5'h00, 3'h7, 1'h1, 16'hFFFF);
    rd(9'h107, 16'h0000);
    rd(9'h004, 16'h0000);
    // Lower buffers fill but never raise an overflow
    eng.beat(5'h08, 3'h7, 1'h1, 16'h0300);
    rd(9'h147, 16'h0300);
    rd(9'h004, 16'h0100);
    eng.beat(5'h08, 3'h7, 1'h1, 16'h1F00);
    rd(9'h147, 16'h0300);
    rd(9'h006, 16'h0000);
    wr(9'h004, 16'hFEFF);
    rd(9'h004, 16'h0000);
    print_verdict();
  end
endmodule : tb
